// file: design/cps_pkg.sv
// Constants, types and helpers for the clock prescaler, PLL and sleep control block
// Behaviour
// [RL1] CPU, flash, I/O and converter clocks are the source divided by selected factor
// [RL2] A division change never produces a glitch on the derived clocks
// [RL3] No intermediate period is shorter than both the old and new periods
// [RL4] New rate takes effect after the old period ends plus one new period
// [RL5] Software writes change-enable alone, then the new division within four cycles
// [RL6] Change-enable updates only when all other divider register bits are written zero
// [RL7] Change-enable clears four cycles after setting or when the division is written
// [RL8] Rewriting change-enable while open neither restarts the window nor clears it
// [RL9] Division code n gives two to the n for codes 0 to 8; 9 to 15 reserved
// [RL10] Division field resets to 0000, or 0011 when the divide-by-eight fuse is set
// [RL11] Software keeps interrupts off across the two-write divider change
// [RL12] USB PLL multiplies a 2 MHz prescaled reference by 24; RC oscillator unusable
// [RL13] PLL prescaler divides by 4 for 011 and 8 for 101 or 110; others reserved
// [RL14] Upper three bits of the PLL control register always read zero
// [RL15] PLL enable starts the PLL; lock flag sets about 100 ms later
// [RL16] Lock flag clears only when enable and prescaler bits are all cleared
// [RL17] Sleep entered only on sleep instruction with sleep-enable set; mode bits choose
// [RL18] Mode codes: idle, noise reduction, power-down, power-save, standby, extended standby
// [RL19] Wake on interrupt halts core four cycles past start-up, then resumes
// [RL20] Reset during sleep wakes the core into the reset vector
// [RL21] Waking leaves the register file and static memory untouched
// [RL22] Software sets sleep-enable just before sleeping and clears it after waking
// [RL23] Noise reduction stops I/O, CPU and flash clocks; others including USB run
// [RL24] Power-down stops every generated clock
// [RL25] Standby with oscillator running resumes six cycles after a wake-up condition
// [RL26] Change-enable window counts cycles of the active divided system clock
package cps_pkg;

	localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV_CTRL = 8'h01;
	localparam logic [7:0] ADDR_PLL_CTRL = 8'h02;

	localparam int DIV_CE_BIT = 7;
	localparam int PLL_EN_BIT = 1;
	localparam int SLEEP_EN_BIT = 0;
	localparam logic [7:0] DIV_UNLOCK_WORD = 8'h80;

	localparam logic [3:0] DIV_SEL_NODIV = 4'h0;
	localparam logic [3:0] DIV_SEL_DIV8 = 4'h3;
	localparam logic [3:0] DIV_SEL_MAX = 4'h8;
	localparam logic [2:0] PRESC_RST = 3'h0;
	localparam logic [2:0] PRESC_DIV4 = 3'h3;
	localparam logic [2:0] PRESC_DIV8_A = 3'h5;
	localparam logic [2:0] PRESC_DIV8_B = 3'h6;
	localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
	localparam logic [1:0] INIT_LOAD = 2'h2;
	localparam logic [1:0] INIT_DONE = 2'h3;

	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned CE_WIN_CYC = 4;
	localparam int unsigned HOLD_CYC = 4;
	localparam int unsigned STANDBY_WAKE_CYC = 6;
	localparam int unsigned PD_WAKE_CYC = 6;
	localparam int unsigned PLL_LOCK_MS = 100;
	localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_MS * CLK_KHZ;
	localparam logic [1:0] CE_LAST = 2'(CE_WIN_CYC - 1);
	localparam logic [2:0] HOLD_LAST = 3'(HOLD_CYC - 1);

	typedef enum logic [2:0] {
		MODE_IDLE = 3'h0,
		MODE_NOISE_RED = 3'h1,
		MODE_POWER_DOWN = 3'h2,
		MODE_POWER_SAVE = 3'h3,
		MODE_RSVD_A = 3'h4,
		MODE_RSVD_B = 3'h5,
		MODE_STANDBY = 3'h6,
		MODE_EXT_STANDBY = 3'h7
	} cps_mode_t;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_START = 2'b11,
		ST_HOLD = 2'b10
	} cps_state_t;

	// Last count of one divided period; reserved codes fall back to the slowest rate
	function automatic logic [7:0] div_last(input logic [3:0] code);
		if (code > DIV_SEL_MAX) begin
			return 8'hff;
		end
		return 8'((9'h001 << code) - 9'h001);
	endfunction : div_last

endpackage : cps_pkg

// file: design/cps_divider.sv
// Glitch-free system clock divider producing one tick per divided period
`timescale 1ns/10ps
`default_nettype none
module cps_divider (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] sel,
	output logic tick_q
);

	logic [7:0] cnt_q;
	logic [3:0] cur_q;
	logic period_end;

	assign period_end = (cnt_q == cps_pkg::div_last(cur_q));

	// New setting is only adopted at an old-period boundary, so no runt period appears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			cur_q <= cps_pkg::DIV_SEL_NODIV;
		end else if (period_end) begin
			cnt_q <= 8'h00;
			cur_q <= sel; // [RL2] [RL3] [RL4]
		end else begin
			cnt_q <= cnt_q + 8'h01; // [RL1] [RL9]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= period_end;
		end
	end

	a_setting_at_edge: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
		$changed(cur_q) |-> $past(period_end))
		else $error("divider setting changed inside a period");

	a_new_period: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
		period_end |=> (cnt_q == 8'h00) && (cur_q == $past(sel)) ##0 tick_q)
		else $error("divider did not start the new period");

endmodule : cps_divider
`default_nettype wire

// file: design/cps_pll_lock.sv
// USB PLL enable and lock detection timer
`timescale 1ns/10ps
`default_nettype none
module cps_pll_lock #(
	parameter int unsigned LOCK_CYC = cps_pkg::PLL_LOCK_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [2:0] presc,
	input wire logic ref_ok,
	output logic lock_q
);

	logic [21:0] cnt_q;
	logic clear;
	logic running;

	assign clear = !enable && (presc == cps_pkg::PRESC_RST);
	assign running = enable && ref_ok;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 22'h000000;
			lock_q <= 1'b0;
		end else if (clear) begin
			cnt_q <= 22'h000000;
			lock_q <= 1'b0; // [RL16]
		end else if (running && !lock_q) begin
			if (cnt_q == 22'(LOCK_CYC - 1)) begin
				lock_q <= 1'b1; // [RL15]
			end else begin
				cnt_q <= cnt_q + 22'h000001;
			end
		end
	end

	a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
		(lock_q && !clear) |=> lock_q)
		else $error("lock flag dropped without a clear");

	a_lock_timed: assert property (@(posedge clk) disable iff (!rst_n) // [RL15]
		$rose(lock_q) |-> $past(cnt_q) == 22'(LOCK_CYC - 1) && $past(enable))
		else $error("lock flag set before the lock time");

endmodule : cps_pll_lock
`default_nettype wire

// file: design/cps_top.sv
// System clock control: divider unlock, PLL control and sleep sequencing
`timescale 1ns/10ps
`default_nettype none
module cps_top #(
	parameter int unsigned LOCK_CYC = cps_pkg::PLL_LOCK_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata_q,
	input wire logic divide_by_eight_fuse,
	input wire logic osc_is_rc,
	input wire logic sleep_instr,
	input wire logic wake_irq,
	output logic cpu_clk_en_q,
	output logic flash_clk_en_q,
	output logic io_clk_en_q,
	output logic adc_clk_en_q,
	output logic usb_clk_run_q,
	output logic sleeping_q,
	output logic resume_q
);

	logic rst_m_q;
	logic rst_n_s;
	logic fuse_m_q;
	logic fuse_s_q;
	logic rc_m_q;
	logic rc_s_q;
	logic [1:0] init_q;

	logic sleep_enable_q;
	cps_pkg::cps_mode_t sleep_mode_select_q;
	logic divider_change_enable_q;
	logic [1:0] ce_cnt_q;
	logic [3:0] divider_select_q;
	logic [2:0] pll_input_prescale_q;
	logic pll_enable_q;
	logic pll_lock_flag;

	cps_pkg::cps_state_t st_q;
	logic [2:0] wait_q;
	logic sys_tick;
	logic [4:0] run_mask;

	logic wr_sleep;
	logic wr_div;
	logic wr_pll;
	logic unlock_wr;
	logic sel_wr;
	logic ce_expire;
	logic presc_ok;
	logic [7:0] rd_mux;

	// Start-up wait in divided cycles before the four-cycle halt
	function automatic logic [2:0] wake_len(input cps_pkg::cps_mode_t m);
		case (m)
			cps_pkg::MODE_STANDBY,
			cps_pkg::MODE_EXT_STANDBY: wake_len = 3'(cps_pkg::STANDBY_WAKE_CYC); // [RL25]
			cps_pkg::MODE_POWER_DOWN,
			cps_pkg::MODE_POWER_SAVE: wake_len = 3'(cps_pkg::PD_WAKE_CYC);
			default: wake_len = 3'h0;
		endcase
	endfunction : wake_len

	// Bits are usb, adc, io, flash, cpu
	function automatic logic [4:0] clk_mask(input cps_pkg::cps_state_t s,
		input cps_pkg::cps_mode_t m);
		clk_mask = 5'h1f;
		case (s)
			cps_pkg::ST_RUN: clk_mask = 5'h1f;
			cps_pkg::ST_HOLD: clk_mask = 5'h1c; // [RL19]
			default: begin
				case (m)
					cps_pkg::MODE_IDLE: clk_mask = 5'h1c;
					cps_pkg::MODE_NOISE_RED: clk_mask = 5'h18; // [RL23]
					default: clk_mask = 5'h00; // [RL24]
				endcase
			end
		endcase
	endfunction : clk_mask

	// Reset release
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_s <= rst_m_q;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			fuse_m_q <= 1'b0;
			fuse_s_q <= 1'b0;
			rc_m_q <= 1'b0;
			rc_s_q <= 1'b0;
		end else begin
			fuse_m_q <= divide_by_eight_fuse;
			fuse_s_q <= fuse_m_q;
			rc_m_q <= osc_is_rc;
			rc_s_q <= rc_m_q;
		end
	end

	// Fuse is sampled once the synchroniser holds a settled value
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			init_q <= 2'h0;
		end else if (init_q != cps_pkg::INIT_DONE) begin
			init_q <= init_q + 2'h1;
		end
	end

	assign wr_sleep = wr && (addr == cps_pkg::ADDR_SLEEP_CTRL);
	assign wr_div = wr && (addr == cps_pkg::ADDR_DIV_CTRL);
	assign wr_pll = wr && (addr == cps_pkg::ADDR_PLL_CTRL);
	assign unlock_wr = wr_div && (wdata == cps_pkg::DIV_UNLOCK_WORD); // [RL6]
	assign sel_wr = wr_div && divider_change_enable_q && !wdata[cps_pkg::DIV_CE_BIT]; // [RL5]
	assign ce_expire = sys_tick && (ce_cnt_q == cps_pkg::CE_LAST); // [RL26]

	// Change-enable window
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			divider_change_enable_q <= 1'b0;
			ce_cnt_q <= 2'h0;
		end else if (sel_wr) begin
			divider_change_enable_q <= 1'b0; // [RL7]
			ce_cnt_q <= 2'h0;
		end else if (unlock_wr && !divider_change_enable_q) begin
			divider_change_enable_q <= 1'b1; // [RL6]
			ce_cnt_q <= 2'h0;
		end else if (divider_change_enable_q && ce_expire) begin
			divider_change_enable_q <= 1'b0; // [RL7]
			ce_cnt_q <= 2'h0;
		end else if (divider_change_enable_q && sys_tick) begin
			ce_cnt_q <= ce_cnt_q + 2'h1; // [RL8] [RL26]
		end
	end

	// Division field
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			divider_select_q <= cps_pkg::DIV_SEL_NODIV;
		end else if (init_q == cps_pkg::INIT_LOAD) begin
			divider_select_q <= fuse_s_q ? cps_pkg::DIV_SEL_DIV8
				: cps_pkg::DIV_SEL_NODIV; // [RL10]
		end else if (sel_wr) begin
			divider_select_q <= wdata[3:0]; // [RL5] [RL9]
		end
	end

	cps_divider u_divider (
		.clk(clk),
		.rst_n(rst_n_s),
		.sel(divider_select_q),
		.tick_q(sys_tick)
	);

	// Sleep mode control register
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			sleep_enable_q <= cps_pkg::SLEEP_CTRL_RST[cps_pkg::SLEEP_EN_BIT];
			sleep_mode_select_q <= cps_pkg::cps_mode_t'(cps_pkg::SLEEP_CTRL_RST[3:1]);
		end else if (wr_sleep) begin
			sleep_enable_q <= wdata[cps_pkg::SLEEP_EN_BIT];
			sleep_mode_select_q <= cps_pkg::cps_mode_t'(wdata[3:1]); // [RL18]
		end
	end

	// PLL control
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pll_input_prescale_q <= cps_pkg::PRESC_RST;
			pll_enable_q <= 1'b0;
		end else if (wr_pll) begin
			pll_input_prescale_q <= wdata[4:2];
			pll_enable_q <= wdata[cps_pkg::PLL_EN_BIT]; // [RL15]
		end
	end

	// Only the divide-by-4 and divide-by-8 codes give the 2 MHz reference
	assign presc_ok = (pll_input_prescale_q == cps_pkg::PRESC_DIV4)
		|| (pll_input_prescale_q == cps_pkg::PRESC_DIV8_A)
		|| (pll_input_prescale_q == cps_pkg::PRESC_DIV8_B); // [RL13]

	cps_pll_lock #(
		.LOCK_CYC(LOCK_CYC)
	) u_pll_lock (
		.clk(clk),
		.rst_n(rst_n_s),
		.enable(pll_enable_q),
		.presc(pll_input_prescale_q),
		.ref_ok(presc_ok && !rc_s_q), // [RL12]
		.lock_q(pll_lock_flag)
	);

	// Sleep sequencer; reset returns straight to run from any state
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_q <= cps_pkg::ST_RUN; // [RL20]
			wait_q <= 3'h0;
		end else begin
			case (st_q)
				cps_pkg::ST_RUN: begin
					if (sleep_instr && sleep_enable_q
						&& sleep_mode_select_q != cps_pkg::MODE_RSVD_A
						&& sleep_mode_select_q != cps_pkg::MODE_RSVD_B) begin
						st_q <= cps_pkg::ST_SLEEP; // [RL17]
					end
				end
				cps_pkg::ST_SLEEP: begin
					wait_q <= 3'h0;
					if (wake_irq) begin
						st_q <= (wake_len(sleep_mode_select_q) == 3'h0)
							? cps_pkg::ST_HOLD : cps_pkg::ST_START;
					end
				end
				cps_pkg::ST_START: begin
					if (sys_tick) begin
						if (wait_q == wake_len(sleep_mode_select_q) - 3'h1) begin
							st_q <= cps_pkg::ST_HOLD; // [RL25]
							wait_q <= 3'h0;
						end else begin
							wait_q <= wait_q + 3'h1;
						end
					end
				end
				cps_pkg::ST_HOLD: begin
					if (sys_tick) begin
						if (wait_q == cps_pkg::HOLD_LAST) begin
							st_q <= cps_pkg::ST_RUN; // [RL19]
							wait_q <= 3'h0;
						end else begin
							wait_q <= wait_q + 3'h1;
						end
					end
				end
				default: begin
					st_q <= cps_pkg::ST_RUN;
					wait_q <= 3'h0;
				end
			endcase
		end
	end

	// Sleep only gates clocks; no storage is touched, so contents survive
	assign run_mask = clk_mask(st_q, sleep_mode_select_q); // [RL21]

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			cpu_clk_en_q <= 1'b0;
			flash_clk_en_q <= 1'b0;
			io_clk_en_q <= 1'b0;
			adc_clk_en_q <= 1'b0;
		end else begin
			cpu_clk_en_q <= sys_tick && run_mask[0]; // [RL1]
			flash_clk_en_q <= sys_tick && run_mask[1];
			io_clk_en_q <= sys_tick && run_mask[2];
			adc_clk_en_q <= sys_tick && run_mask[3];
		end
	end

	// USB clock needs a locked PLL fed from a crystal, not the RC oscillator
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			usb_clk_run_q <= 1'b0;
		end else begin
			usb_clk_run_q <= pll_lock_flag && !rc_s_q && run_mask[4]; // [RL12] [RL23]
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			sleeping_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			sleeping_q <= (st_q != cps_pkg::ST_RUN);
			resume_q <= (st_q == cps_pkg::ST_HOLD) && sys_tick
				&& (wait_q == cps_pkg::HOLD_LAST); // [RL19]
		end
	end

	always_comb begin
		case (addr)
			cps_pkg::ADDR_SLEEP_CTRL: rd_mux = {4'h0, sleep_mode_select_q, sleep_enable_q};
			cps_pkg::ADDR_DIV_CTRL: rd_mux = {divider_change_enable_q, 3'h0, divider_select_q};
			cps_pkg::ADDR_PLL_CTRL: rd_mux = {3'h0, pll_input_prescale_q, pll_enable_q,
				pll_lock_flag}; // [RL14]
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			rdata_q <= 8'h00;
		end else if (rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	a_unlock_only: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL6]
		$rose(divider_change_enable_q) |-> $past(wr_div && wdata == cps_pkg::DIV_UNLOCK_WORD))
		else $error("change enable set by a non-unlock write");

	a_no_restart: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL8]
		(divider_change_enable_q && unlock_wr && !ce_expire) |=>
		divider_change_enable_q && ce_cnt_q >= $past(ce_cnt_q))
		else $error("unlock rewrite restarted or cleared the window");

	a_window_close: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL7]
		(divider_change_enable_q && ce_expire) |=> !divider_change_enable_q)
		else $error("change enable outlived its window");

	a_sel_guarded: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL5]
		($changed(divider_select_q) && $past(init_q) == cps_pkg::INIT_DONE)
		|-> $past(divider_change_enable_q) && !divider_change_enable_q)
		else $error("division changed without an open window");

	a_sleep_gate: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL17]
		(st_q == cps_pkg::ST_RUN && !sleep_enable_q) |=> st_q == cps_pkg::ST_RUN)
		else $error("sleep entered without sleep enable");

	a_hold_halts: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL19]
		(st_q == cps_pkg::ST_HOLD) |=> !cpu_clk_en_q && !flash_clk_en_q)
		else $error("core clock ran during wake halt");

	a_pd_stops: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL24]
		(st_q == cps_pkg::ST_SLEEP && sleep_mode_select_q == cps_pkg::MODE_POWER_DOWN)
		|=> !(cpu_clk_en_q || flash_clk_en_q || io_clk_en_q || adc_clk_en_q || usb_clk_run_q))
		else $error("clock ran in power-down");

	a_noise_red: assert property (@(posedge clk) disable iff (!rst_n_s) // [RL23]
		(st_q == cps_pkg::ST_SLEEP && sleep_mode_select_q == cps_pkg::MODE_NOISE_RED)
		|=> !(cpu_clk_en_q || flash_clk_en_q || io_clk_en_q) && (adc_clk_en_q == $past(sys_tick)))
		else $error("noise reduction clock gating wrong");

endmodule : cps_top
`default_nettype wire

// file: testbench/cps_top_bench.sv
// Self-checking bench for the clock prescaler, PLL and sleep control block
`timescale 1ns/10ps
`default_nettype none
module cps_top_bench;
	localparam int unsigned LOCK_T = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fuse = 1'b1;
	logic osc_rc = 1'b1;
	logic sleep_instr = 1'b0;
	logic wake_irq = 1'b0;
	logic [7:0] rdata_q;
	logic cpu_en, flash_en, io_en, adc_en, usb_run, sleeping, resume;
	int n_errors = 0;
	int n_compared = 0;

	cps_top #(.LOCK_CYC(LOCK_T)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_q(rdata_q), .divide_by_eight_fuse(fuse), .osc_is_rc(osc_rc),
		.sleep_instr(sleep_instr), .wake_irq(wake_irq), .cpu_clk_en_q(cpu_en),
		.flash_clk_en_q(flash_en), .io_clk_en_q(io_en), .adc_clk_en_q(adc_en),
		.usb_clk_run_q(usb_run), .sleeping_q(sleeping), .resume_q(resume));

	always #12.5 clk = ~clk;

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	task automatic chkn(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("BAD %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chkn

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk8(what, exp, rdata_q);
	endtask : rchk

	task automatic pulse_sleep;
		@(posedge clk);
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse_sleep

	// Cycles up to and including the next cpu enable pulse, bounded
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (cpu_en !== 1'b1 && n < 600);
	endtask : wait_tick

	task automatic cnt(input int n, output int c_cpu, output int c_io, output int c_adc);
		c_cpu = 0;
		c_io = 0;
		c_adc = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			c_cpu += (cpu_en === 1'b1 && flash_en === 1'b1) ? 1 : 0;
			c_io += (io_en === 1'b1) ? 1 : 0;
			c_adc += (adc_en === 1'b1) ? 1 : 0;
		end
	endtask : cnt

	task automatic do_reset;
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask : do_reset

	function automatic int per(input int c);
		return (c > 8) ? 256 : (1 << c);
	endfunction : per

	initial begin
		#(25ns * 60000);
		n_errors++;
		$display("BAD watchdog expected done seen hang");
		end_sim();
	end

	initial begin
		int codes[8];
		int modes[8];
		int po, pn, g1, g2, g3, g4, a, b, c, n, ex, mn;
		logic [2:0] p;
		logic rsv;
		void'($urandom(32'h2f97));
		do_reset();
		rchk(8'h00, 8'h00, "sleep ctrl reset");
		rchk(8'h01, 8'h03, "divider reset fuse set");
		rchk(8'h02, 8'h00, "pll reset");
		rchk(8'h05, 8'h00, "unmapped read");
		wr_reg(8'h05, 8'hff);
		// Unlock sequence, written as software must
		wr_reg(8'h01, 8'h80);
		rchk(8'h01, 8'h83, "change enable set");
		wr_reg(8'h01, 8'h80);
		rchk(8'h01, 8'h83, "rewrite keeps flag");
		repeat (40) @(posedge clk);
		rchk(8'h01, 8'h03, "flag timed out");
		wr_reg(8'h01, 8'h81);
		rchk(8'h01, 8'h03, "unlock with other bits");
		wr_reg(8'h01, 8'h05);
		rchk(8'h01, 8'h03, "locked select write");
		// Corner codes with random ones between them, ending undivided
		codes = '{8, 0, 0, 0, 0, 9, 2, 0};
		for (int i = 2; i < 5; i++) begin
			codes[i] = $urandom % 9;
		end
		po = 8;
		foreach (codes[i]) begin
			pn = per(codes[i]);
			wr_reg(8'h01, 8'h80);
			wr_reg(8'h01, 8'(codes[i]));
			wait_tick(g1);
			wait_tick(g2);
			wait_tick(g3);
			wait_tick(g4);
			chkn("settled period", pn, g4);
			mn = (po < pn) ? po : pn;
			chkn("no short gap", 1, int'(g2 >= mn && g3 >= mn));
			chkn("switch time", 1, int'(g1 + g2 <= po + 2 * pn + 2));
			rchk(8'h01, 8'(codes[i]), "select readback");
			po = pn;
		end
		// PLL: source on RC oscillator must not give a USB clock
		p = 3'h3 + 3'($urandom % 3);
		p = (p == 3'h4) ? 3'h6 : p;
		wr_reg(8'h02, {3'h0, p, 2'b10});
		repeat (LOCK_T + 10) @(posedge clk);
		#1;
		chk8("usb on rc", 8'h00, {7'h0, usb_run});
		@(posedge clk);
		osc_rc <= 1'b0;
		repeat (LOCK_T / 2) @(posedge clk);
		rchk(8'h02, {3'h0, p, 2'b10}, "lock early");
		repeat (LOCK_T + 10) @(posedge clk);
		rchk(8'h02, {3'h0, p, 2'b11}, "lock set");
		chk8("usb run", 8'h01, {7'h0, usb_run});
		wr_reg(8'h02, {3'h0, p, 2'b00});
		rchk(8'h02, {3'h0, p, 2'b01}, "lock held");
		wr_reg(8'h02, 8'h00);
		rchk(8'h02, 8'h00, "lock cleared");
		wr_reg(8'h02, 8'hfe);
		rchk(8'h02, 8'h1e, "reserved bits");
		wr_reg(8'h02, {3'h0, p, 2'b10});
		repeat (LOCK_T + 10) @(posedge clk);
		// Sleep enable clear: sleep instruction ignored
		wr_reg(8'h00, 8'h00);
		pulse_sleep();
		chk8("sleep without enable", 8'h00, {7'h0, sleeping});
		modes = '{0, 1, 2, 3, 6, 7, 4, 5};
		foreach (modes[i]) begin
			rsv = (modes[i] == 4 || modes[i] == 5);
			wr_reg(8'h00, {4'h0, 3'(modes[i]), 1'b1});
			rchk(8'h00, {4'h0, 3'(modes[i]), 1'b1}, "sleep ctrl");
			pulse_sleep();
			chk8("sleeping", {7'h0, !rsv}, {7'h0, sleeping});
			cnt(16, a, b, c);
			chkn("cpu flash pulses", rsv ? 16 : 0, a);
			chkn("io pulses", (rsv || modes[i] == 0) ? 16 : 0, b);
			chkn("adc pulses", (rsv || modes[i] < 2) ? 16 : 0, c);
			chk8("usb in sleep", {7'h0, rsv || modes[i] < 2}, {7'h0, usb_run});
			if (!rsv) begin
				@(posedge clk);
				wake_irq <= 1'b1;
				@(posedge clk);
				wake_irq <= 1'b0;
				n = 0;
				ex = (modes[i] < 2 ? 0 : 6) + 4;
				do begin
					@(posedge clk);
					#1;
					n++;
				end while (resume !== 1'b1 && n < 40);
				chkn("wake latency", 1, int'(n >= ex - 1 && n <= ex + 3));
				repeat (2) @(posedge clk);
				#1;
				chk8("awake", 8'h00, {7'h0, sleeping});
			end
			wr_reg(8'h00, 8'h00);
		end
		// Reset in power-down with the fuse now clear
		wr_reg(8'h00, 8'h05);
		pulse_sleep();
		@(posedge clk);
		fuse <= 1'b0;
		rstn <= 1'b0;
		#1;
		chk8("reset wakes", 8'h00, {7'h0, sleeping});
		do_reset();
		chk8("run after reset", 8'h00, {7'h0, sleeping});
		rchk(8'h01, 8'h00, "divider reset fuse clear");
		cnt(8, a, b, c);
		chkn("undivided after reset", 8, a);
		end_sim();
	end
endmodule : cps_top_bench
`default_nettype wire
